// ### hw/ptc_edge_det.sv
`timescale 1ns/1ps
// rising and falling edge pulses for a group of synchronous inputs
module ptc_edge_det #(
	parameter int N = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [N-1:0] din,
	output logic [N-1:0] rise,
	output logic [N-1:0] fall
);
	logic [N-1:0] prev_ff;

	// previous sample; starts low so an input high at release counts as a rise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_ff <= '0;
		end else if (ce) begin
			prev_ff <= din;
		end
	end

	// gated by ce so an edge is seen for exactly one enabled cycle
	for (genvar i = 0; i < N; i++) begin : g_edge
		assign rise[i] = ce & din[i] & ~prev_ff[i];
		assign fall[i] = ce & ~din[i] & prev_ff[i];
	end
endmodule // ptc_edge_det

// ### hw/ptc_pkg.sv
package ptc_pkg;
	// clock and time base
	localparam longint unsigned CLK_HZ = 125000000;
	localparam int unsigned WRAP_PULSE_S = 2;
	localparam int unsigned WRAP_PULSE_CYC = WRAP_PULSE_S * int'(CLK_HZ);
	localparam int WRAP_TW = 28;

	// totals are fixed point, five decimal places below the engineering unit
	localparam int TOT_W = 48;
	localparam int HI_W = TOT_W - 32;
	localparam int RATE_W = 24;
	localparam int AIN_W = 16;
	localparam int WGT_W = 27;
	localparam int DP_W = 3;
	localparam logic [DP_W-1:0] DP_MAX = 3'h5;
	localparam logic [TOT_W-1:0] STEP_TBL [0:5] = '{48'h186A0, 48'h2710, 48'h3E8,
		48'h64, 48'hA, 48'h1};

	// one analog pulse per THRESH of accumulated rate x input
	localparam longint unsigned FS_E5 = 100000;
	localparam longint unsigned AIN_FS = 65536;
	localparam logic [63:0] PULSE_THRESH = 64'(FS_E5 * AIN_FS * CLK_HZ);

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RATE = 8'h0C;
	localparam logic [7:0] REG_CUTOFF = 8'h10;
	localparam logic [7:0] REG_WEIGHT = 8'h14;
	localparam logic [7:0] REG_DECPL = 8'h18;
	localparam logic [7:0] REG_LOGINT = 8'h1C;
	localparam logic [7:0] REG_PRESET_LO = 8'h20;
	localparam logic [7:0] REG_PRESET_HI = 8'h24;
	localparam logic [7:0] REG_END_LO = 8'h28;
	localparam logic [7:0] REG_END_HI = 8'h2C;
	localparam logic [7:0] REG_INTER_LO = 8'h30;
	localparam logic [7:0] REG_INTER_HI = 8'h34;
	localparam logic [7:0] REG_TOTAL_LO = 8'h38;
	localparam logic [7:0] REG_TOTAL_HI = 8'h3C;
	localparam logic [7:0] REG_LOGTOT_LO = 8'h40;
	localparam logic [7:0] REG_LOGTOT_HI = 8'h44;

	// command bits (write-one pulses)
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_RESET = 2;
	localparam int CMD_LOG = 3;

	// edge-detected input lanes
	localparam int EV_N = 4;
	localparam int EV_RUN = 0;
	localparam int EV_RST = 1;
	localparam int EV_LOG = 2;
	localparam int EV_DIG = 3;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_UP = 2'h1;
	localparam logic [1:0] MODE_DOWN = 2'h2;
	localparam logic [1:0] REC_LAST = 2'h0;
	localparam logic [1:0] REC_STOP = 2'h1;
	localparam logic [1:0] REC_GO = 2'h2;

	// periodic log interval codes: 1..6 minutes past the hour, 7..12 hours from midnight
	localparam int LOG_CODES = 12;
	localparam int LOG_MIN_CODES = 6;
	localparam int unsigned LOG_DIV [0:12] = '{0, 5, 10, 15, 20, 30, 60, 2, 3, 4, 8, 12, 24};

	localparam int CTRL_W = 6;
	typedef struct packed {
		logic src_dig;
		logic [1:0] recov;
		logic wrap;
		logic [1:0] mode;
	} ptc_ctrl_type;

	localparam ptc_ctrl_type CTRL_RST = '{src_dig: 1'b0, recov: REC_LAST, wrap: 1'b0,
		mode: MODE_OFF};
	localparam logic [RATE_W-1:0] RATE_RST = 24'hF4240;
	localparam logic [WGT_W-1:0] WGT_RST = 27'h186A0;

	typedef enum logic [2:0] {
		ST_STOPPED = 3'h1,
		ST_RUNNING = 3'h2,
		ST_HALTED = 3'h4
	} ptc_state_type;
endpackage

// ### hw/ptc_totalizer.sv
`timescale 1ns/1ps
// Overview of operation
// - analog source counts rate pulses; digital source counts off-to-on transitions
// - up direction counts from preset towards endpoint
// - wrap on reloads preset when the endpoint is reached
// - wrap off halts and holds the endpoint value
// - wrap on gives a two second wrap pulse at each endpoint
// - wrap off holds wrap output until the next totalizer reset
// - power recovery applies last, stop or go option
// - run input rising edge starts, falling edge stops counting
// - preset is both start value and the value loaded on reset
// - threshold flag goes active when total reaches intermediate count
// - rising edge of reset input reloads preset
// - rising edge of log input captures totals into log record
// - periodic log at minute multiples past hour or hour multiples from midnight
// - smallest increment follows endpoint decimal places
// - analog counting suppressed while input is below cut-off
// - digital transitions add a weight from 0.00001 to 1000.00000
module ptc_totalizer
	import ptc_pkg::*;
#(
	parameter int unsigned WRAP_CYC = WRAP_PULSE_CYC
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic [AIN_W-1:0] ANALOG_IN,
	input wire logic DIG_IN,
	input wire logic RUN_SRC,
	input wire logic RESET_SRC,
	input wire logic LOG_SRC,
	input wire logic PWR_RECOVER,
	input wire logic [4:0] TOD_HOUR,
	input wire logic [5:0] TOD_MIN,
	output logic WRAP_OUT,
	output logic THRESH_OUT,
	output logic LOG_STB,
	output logic RUNNING
);
	ptc_ctrl_type ctrl_ff;
	logic [RATE_W-1:0] rate_ff;
	logic [AIN_W-1:0] cutoff_ff;
	logic [WGT_W-1:0] weight_ff;
	logic [DP_W-1:0] decpl_ff;
	logic [3:0] logint_ff;
	logic [TOT_W-1:0] preset_ff;
	logic [TOT_W-1:0] end_ff;
	logic [TOT_W-1:0] inter_ff;
	logic [TOT_W-1:0] total_ff;
	logic [TOT_W-1:0] nxt_total;
	logic [TOT_W-1:0] log_tot_ff;
	logic [15:0] log_cnt_ff;
	logic log_stb_ff;
	logic thresh_ff;
	logic wrap_latch_ff;
	logic [WRAP_TW-1:0] wrap_tmr_ff;
	logic [63:0] acc_ff;
	logic [5:0] min_prev_ff;
	logic [31:0] rdata_ff;
	ptc_state_type state_ff;
	ptc_state_type nxt_state;

	logic [EV_N-1:0] ev_rise;
	logic [EV_N-1:0] ev_fall;
	logic wr_en;
	logic [3:0] cmd;
	logic start_ev;
	logic stop_ev;
	logic reset_ev;
	logic log_ev;
	logic periodic_ev;
	logic active;
	logic is_up;
	logic pulse;
	logic analog_on;
	logic [63:0] acc_sum;
	logic [TOT_W-1:0] step;
	logic [TOT_W-1:0] delta;
	logic [TOT_W-1:0] sum_up;
	logic [TOT_W-1:0] sum_dn;
	logic reach;
	logic [31:0] rd_val;

	// true when the wall clock sits on a boundary of the chosen log interval
	function automatic logic log_aligned(input logic [3:0] code, input logic [4:0] hr,
		input logic [5:0] mn);
		logic hit;
		hit = 1'b0;
		for (int i = 1; i <= LOG_CODES; i++) begin
			if (code == 4'(i)) begin
				if (i <= LOG_MIN_CODES) begin
					hit = ((32'(mn) % LOG_DIV[i]) == 32'h0);
				end else begin
					hit = (mn == 6'h0) && ((32'(hr) % LOG_DIV[i]) == 32'h0);
				end
			end
		end
		return hit;
	endfunction

	ptc_edge_det #(
		.N(EV_N)
	) u_edges (
		.clk(MCLK),
		.rst(RST),
		.ce(CE),
		.din({DIG_IN, LOG_SRC, RESET_SRC, RUN_SRC}),
		.rise(ev_rise),
		.fall(ev_fall)
	);

	// software commands are one-cycle pulses decoded from the write strobe
	assign wr_en = CE & WR;
	assign cmd = (wr_en && ADDR == REG_CMD) ? WDATA[3:0] : 4'h0;

	// run, reset and log events from edges and from software
	assign start_ev = ev_rise[EV_RUN] | cmd[CMD_START];
	assign stop_ev = ev_fall[EV_RUN] | cmd[CMD_STOP];
	assign reset_ev = ev_rise[EV_RST] | cmd[CMD_RESET];
	assign periodic_ev = CE && logint_ff != 4'h0 && TOD_MIN != min_prev_ff
		&& log_aligned(logint_ff, TOD_HOUR, TOD_MIN);
	assign log_ev = ev_rise[EV_LOG] | cmd[CMD_LOG] | periodic_ev;

	// configuration registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_ff <= CTRL_RST;
			rate_ff <= RATE_RST;
			cutoff_ff <= '0;
			weight_ff <= WGT_RST;
			decpl_ff <= '0;
			logint_ff <= '0;
			preset_ff <= '0;
			end_ff <= '0;
			inter_ff <= '0;
		end else if (wr_en) begin
			case (ADDR)
				REG_CTRL: ctrl_ff <= ptc_ctrl_type'(WDATA[CTRL_W-1:0]);
				REG_RATE: rate_ff <= WDATA[RATE_W-1:0];
				REG_CUTOFF: cutoff_ff <= WDATA[AIN_W-1:0];
				REG_WEIGHT: weight_ff <= WDATA[WGT_W-1:0];
				REG_DECPL: decpl_ff <= WDATA[DP_W-1:0];
				REG_LOGINT: logint_ff <= WDATA[3:0];
				REG_PRESET_LO: preset_ff[31:0] <= WDATA;
				REG_PRESET_HI: preset_ff[TOT_W-1:32] <= WDATA[HI_W-1:0];
				REG_END_LO: end_ff[31:0] <= WDATA;
				REG_END_HI: end_ff[TOT_W-1:32] <= WDATA[HI_W-1:0];
				REG_INTER_LO: inter_ff[31:0] <= WDATA;
				REG_INTER_HI: inter_ff[TOT_W-1:32] <= WDATA[HI_W-1:0];
				default: ;
			endcase
		end
	end

	// counting only while running with a direction chosen
	assign is_up = (ctrl_ff.mode == MODE_UP);
	assign active = (state_ff == ST_RUNNING) && (is_up || ctrl_ff.mode == MODE_DOWN);

	// smallest increment; more places than the fraction holds clamp to one lsb
	assign step = STEP_TBL[(decpl_ff > DP_MAX) ? DP_MAX : decpl_ff];

	// analog rate generator: phase accumulator of rate x input, one pulse per threshold
	assign analog_on = CE && active && !ctrl_ff.src_dig && ANALOG_IN >= cutoff_ff;
	assign acc_sum = acc_ff + 64'(rate_ff) * 64'(ANALOG_IN);
	assign pulse = analog_on && acc_sum >= PULSE_THRESH;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			acc_ff <= '0;
		end else if (analog_on) begin
			acc_ff <= pulse ? acc_sum - PULSE_THRESH : acc_sum;
		end
	end

	// amount added or removed this cycle
	always_comb begin
		delta = '0;
		if (ctrl_ff.src_dig) begin
			if (ev_rise[EV_DIG] && active) begin
				delta = TOT_W'(weight_ff);
			end
		end else if (pulse) begin
			delta = step;
		end
	end

	// endpoint test is made before the add so the total never overshoots
	assign sum_up = total_ff + delta;
	assign sum_dn = total_ff - delta;
	assign reach = !reset_ev && delta != '0
		&& (is_up ? sum_up >= end_ff : total_ff <= end_ff + delta);

	// next total: reset has priority, then endpoint handling
	always_comb begin
		nxt_total = total_ff;
		if (reset_ev) begin
			nxt_total = preset_ff;
		end else if (reach) begin
			nxt_total = ctrl_ff.wrap ? preset_ff : end_ff;
		end else if (delta != '0) begin
			nxt_total = is_up ? sum_up : sum_dn;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			total_ff <= '0;
		end else if (CE) begin
			total_ff <= nxt_total;
		end
	end

	// run state; a stop and a start in one cycle resolves to stop
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_STOPPED: begin
				if (start_ev && !stop_ev) begin
					nxt_state = ST_RUNNING;
				end
			end
			ST_RUNNING: begin
				if (stop_ev) begin
					nxt_state = ST_STOPPED;
				end else if (reach && !ctrl_ff.wrap) begin
					nxt_state = ST_HALTED;
				end
			end
			ST_HALTED: begin
				if (reset_ev) begin
					nxt_state = ST_RUNNING;
				end
			end
			default: nxt_state = ST_STOPPED;
		endcase
		// recovery overrides the edges; a halted total stays halted until reset
		if (PWR_RECOVER && state_ff != ST_HALTED) begin
			if (ctrl_ff.recov == REC_STOP) begin
				nxt_state = ST_STOPPED;
			end else if (ctrl_ff.recov == REC_GO) begin
				nxt_state = ST_RUNNING;
			end
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_ff <= ST_STOPPED;
		end else if (CE) begin
			state_ff <= nxt_state;
		end
	end

	// wrap output: timed pulse with wrap on, latched level with wrap off
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wrap_tmr_ff <= '0;
		end else if (CE) begin
			if (reset_ev) begin
				wrap_tmr_ff <= '0;
			end else if (reach && ctrl_ff.wrap) begin
				wrap_tmr_ff <= WRAP_TW'(WRAP_CYC);
			end else if (wrap_tmr_ff != '0) begin
				wrap_tmr_ff <= wrap_tmr_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wrap_latch_ff <= 1'b0;
		end else if (CE) begin
			if (reach && !ctrl_ff.wrap) begin
				wrap_latch_ff <= 1'b1;
			end else if (reset_ev) begin
				wrap_latch_ff <= 1'b0;
			end
		end
	end

	// threshold compares the registered total, so it trails the total by one cycle
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			thresh_ff <= 1'b0;
		end else if (CE) begin
			if (ctrl_ff.mode == MODE_DOWN) begin
				thresh_ff <= total_ff <= inter_ff;
			end else begin
				thresh_ff <= total_ff >= inter_ff;
			end
		end
	end

	// log record and wall clock minute tracking
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			log_tot_ff <= '0;
			log_cnt_ff <= '0;
			log_stb_ff <= 1'b0;
			min_prev_ff <= '0;
		end else if (CE) begin
			min_prev_ff <= TOD_MIN;
			log_stb_ff <= log_ev;
			if (log_ev) begin
				log_tot_ff <= total_ff;
				log_cnt_ff <= log_cnt_ff + 1'b1;
			end
		end
	end

	// read decode; unmapped and write-only offsets read zero
	always_comb begin
		rd_val = '0;
		case (ADDR)
			REG_CTRL: rd_val = 32'(ctrl_ff);
			REG_STATUS: rd_val = {log_cnt_ff, 12'h0, thresh_ff, WRAP_OUT,
				state_ff == ST_HALTED, state_ff == ST_RUNNING};
			REG_RATE: rd_val = 32'(rate_ff);
			REG_CUTOFF: rd_val = 32'(cutoff_ff);
			REG_WEIGHT: rd_val = 32'(weight_ff);
			REG_DECPL: rd_val = 32'(decpl_ff);
			REG_LOGINT: rd_val = 32'(logint_ff);
			REG_PRESET_LO: rd_val = preset_ff[31:0];
			REG_PRESET_HI: rd_val = 32'(preset_ff[TOT_W-1:32]);
			REG_END_LO: rd_val = end_ff[31:0];
			REG_END_HI: rd_val = 32'(end_ff[TOT_W-1:32]);
			REG_INTER_LO: rd_val = inter_ff[31:0];
			REG_INTER_HI: rd_val = 32'(inter_ff[TOT_W-1:32]);
			REG_TOTAL_LO: rd_val = total_ff[31:0];
			REG_TOTAL_HI: rd_val = 32'(total_ff[TOT_W-1:32]);
			REG_LOGTOT_LO: rd_val = log_tot_ff[31:0];
			REG_LOGTOT_HI: rd_val = 32'(log_tot_ff[TOT_W-1:32]);
			default: rd_val = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rdata_ff <= '0;
		end else if (CE) begin
			rdata_ff <= RD ? rd_val : 32'h0;
		end
	end

	assign RDATA = rdata_ff;
	assign WRAP_OUT = wrap_latch_ff | (wrap_tmr_ff != '0);
	assign THRESH_OUT = thresh_ff;
	assign LOG_STB = log_stb_ff;
	assign RUNNING = (state_ff == ST_RUNNING);
endmodule // ptc_totalizer

// ### tb/ptc_src_model.sv
`timescale 1ns/1ps
// far-side event source: on req emits n off-to-on transitions, two cycles each
module ptc_src_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic [7:0] n,
	output logic dig,
	output logic busy
);
	logic [8:0] cnt_ff;
	// odd counts drive high, so each event has a low gap before its rising edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 9'h0;
		end else if (req && !busy) begin
			cnt_ff <= {n, 1'b0};
		end else if (busy) begin
			cnt_ff <= cnt_ff - 9'h1;
		end
	end
	assign dig = cnt_ff[0];
	assign busy = cnt_ff != 9'h0;
endmodule // ptc_src_model

// ### tb/ptc_totalizer_monitor.sv
`timescale 1ns/1ps
// port-level checks; the config fields they need are shadowed from bus writes
module ptc_totalizer_monitor
	import ptc_pkg::*;
#(
	parameter int unsigned WRAP_CYC = WRAP_PULSE_CYC
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RUN_SRC,
	input wire logic RESET_SRC,
	input wire logic LOG_SRC,
	input wire logic PWR_RECOVER,
	input wire logic [5:0] TOD_MIN,
	input wire logic WRAP_OUT,
	input wire logic LOG_STB,
	input wire logic RUNNING
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	logic wrap_ff;
	logic [1:0] rec_ff;
	logic [3:0] li_ff;
	logic [31:0] hcnt_ff;
	logic rs_ff;
	logic rev_d_ff;
	logic rev;
	// reset event; the latch may clear a cycle late, hence the delayed copy
	assign rev = CE && ((RESET_SRC && !rs_ff) || (WR && ADDR == REG_CMD && WDATA[CMD_RESET]));
	// shadow of wrap, recovery and log interval fields
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wrap_ff <= 1'b0;
			rec_ff <= REC_LAST;
			li_ff <= 4'h0;
		end else if (CE && WR && ADDR == REG_CTRL) begin
			wrap_ff <= WDATA[2];
			rec_ff <= WDATA[4:3];
		end else if (CE && WR && ADDR == REG_LOGINT) begin
			li_ff <= WDATA[3:0];
		end
	end
	// length of the current wrap output run and reset edge history
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			hcnt_ff <= 32'h0;
			rs_ff <= 1'b0;
			rev_d_ff <= 1'b0;
		end else if (CE) begin
			hcnt_ff <= WRAP_OUT ? hcnt_ff + 32'h1 : 32'h0;
			rs_ff <= RESET_SRC;
			rev_d_ff <= rev;
		end
	end
	property p_run_start; CE && $rose(RUN_SRC) && !WRAP_OUT |-> ##[1:3] RUNNING; endproperty
	a_run_start: assert property (p_run_start) else $error("start edge ignored");
	property p_run_stop; CE && $fell(RUN_SRC) |-> ##[1:3] !RUNNING; endproperty
	a_run_stop: assert property (p_run_stop) else $error("stop edge ignored");
	property p_wrap_len; wrap_ff && $fell(WRAP_OUT) |-> hcnt_ff == WRAP_CYC; endproperty
	a_wrap_len: assert property (p_wrap_len) else $error("wrap pulse length");
	property p_wrap_hold; CE && !wrap_ff && WRAP_OUT && !rev && !rev_d_ff |=> WRAP_OUT; endproperty
	a_wrap_hold: assert property (p_wrap_hold) else $error("wrap latch dropped");
	property p_rst_clr; rev |-> ##[1:2] !WRAP_OUT; endproperty
	a_rst_clr: assert property (p_rst_clr) else $error("reset left wrap set");
	property p_log_edge; CE && $rose(LOG_SRC) |-> ##[1:2] LOG_STB; endproperty
	a_log_edge: assert property (p_log_edge) else $error("log edge missed");
	property p_tod_log; CE && li_ff >= 4'h1 && li_ff <= 4'h6 && TOD_MIN != $past(TOD_MIN)
		&& TOD_MIN % LOG_DIV[li_ff] == 0 |-> ##[1:2] LOG_STB; endproperty
	a_tod_log: assert property (p_tod_log) else $error("periodic log missed");
	property p_rec_stop; CE && PWR_RECOVER && rec_ff == REC_STOP |-> ##[1:2] !RUNNING; endproperty
	a_rec_stop: assert property (p_rec_stop) else $error("recovery stop ignored");
	c_wrap: cover property (wrap_ff && $fell(WRAP_OUT));
	c_log: cover property (LOG_STB);
	c_rec: cover property (CE && PWR_RECOVER);
endmodule // ptc_totalizer_monitor

bind ptc_totalizer ptc_totalizer_monitor #(.WRAP_CYC(WRAP_CYC)) i_ptc_totalizer_monitor (
	.MCLK(MCLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RUN_SRC(RUN_SRC),
	.RESET_SRC(RESET_SRC), .LOG_SRC(LOG_SRC), .PWR_RECOVER(PWR_RECOVER), .TOD_MIN(TOD_MIN),
	.WRAP_OUT(WRAP_OUT), .LOG_STB(LOG_STB), .RUNNING(RUNNING));

// ### tb/ptc_totalizer_tb_top.sv
`timescale 1ns/1ps
// directed bench: digital source up and down, wrap modes, logging, recovery
module ptc_totalizer_tb_top
	import ptc_pkg::*;
;
	localparam int unsigned WC = 20;
	localparam logic [31:0] P = 32'h30D40;
	localparam logic [31:0] W = 32'h186A0;
	logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
	logic run = 1'b0, rsrc = 1'b0, lsrc = 1'b0, pwr = 1'b0, req = 1'b0;
	logic [7:0] addr = 8'h00, np = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [AIN_W-1:0] ain = 16'h0;
	logic [4:0] hr = 5'h0;
	logic [5:0] mn = 6'h0;
	logic dig, wrap, thr, lstb, running, busy;
	int error_cnt = 0, n_checks = 0, stbs = 0, whigh = 0;
	ptc_totalizer #(.WRAP_CYC(WC)) i_ptc_totalizer (.MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ANALOG_IN(ain), .DIG_IN(dig),
		.RUN_SRC(run), .RESET_SRC(rsrc), .LOG_SRC(lsrc), .PWR_RECOVER(pwr), .TOD_HOUR(hr),
		.TOD_MIN(mn), .WRAP_OUT(wrap), .THRESH_OUT(thr), .LOG_STB(lstb), .RUNNING(running));
	ptc_src_model i_ptc_src_model (.clk(mclk), .rst(rst), .req(req), .n(np), .dig(dig),
		.busy(busy));
	// 125 MHz clock
	initial begin
		forever #4 mclk = ~mclk;
	end
	// counts log strobes and wrap output cycles for later comparison
	always @(posedge mclk) begin
		if (lstb === 1'b1) stbs++;
		if (wrap === 1'b1) whigh++;
	end
	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr32(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd32(logic [7:0] a, string nm, logic [31:0] exp);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata, exp);
	endtask
	// asks the source for n events and waits, bounded, until it is idle
	task automatic pulses(logic [7:0] n);
		@(posedge mclk);
		req <= 1'b1;
		np <= n;
		@(posedge mclk);
		req <= 1'b0;
		#1;
		for (int i = 0; busy === 1'b1; i++) begin
			if (i > 900) begin
				error_cnt++;
				conclude();
			end
			tick(1);
		end
		tick(3);
	endtask
	task automatic tod(logic [4:0] h, logic [5:0] m, int e);
		int s;
		s = stbs;
		@(posedge mclk);
		hr <= h;
		mn <= m;
		tick(4);
		chk("tod log", 32'(stbs - s), 32'(e));
	endtask
	task automatic recov(logic [31:0] ctl, logic exp);
		wr32(REG_CTRL, ctl);
		@(posedge mclk) pwr <= 1'b1;
		@(posedge mclk) pwr <= 1'b0;
		tick(3);
		chk("recovery", running, exp);
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd32(REG_CTRL, "ctrl", 32'h0);
		wr32(REG_RATE, 32'h98967F);
		rd32(REG_RATE, "rate", 32'h98967F);
		wr32(REG_PRESET_LO, P);
		wr32(REG_END_LO, P + 5 * W);
		wr32(REG_INTER_LO, P + 3 * W);
		wr32(REG_CTRL, 32'h21);
		wr32(REG_CMD, 32'h4);
		rd32(REG_TOTAL_LO, "preset", P);
		pulses(8'h2);
		rd32(REG_TOTAL_LO, "stopped", P);
		@(posedge mclk) run <= 1'b1;
		tick(3);
		chk("run", running, 1'b1);
		pulses(8'h2);
		rd32(REG_TOTAL_LO, "up", P + 2 * W);
		chk("thr lo", thr, 1'b0);
		pulses(8'h1);
		rd32(REG_TOTAL_LO, "up", P + 3 * W);
		chk("thr hi", thr, 1'b1);
		@(posedge mclk) run <= 1'b0;
		tick(3);
		chk("stop", running, 1'b0);
		pulses(8'h1);
		rd32(REG_TOTAL_LO, "halt", P + 3 * W);
		@(posedge mclk) run <= 1'b1;
		tick(3);
		pulses(8'h3);
		rd32(REG_TOTAL_LO, "end hold", P + 5 * W);
		chk("halted", running, 1'b0);
		tick(30);
		chk("wrap latch", wrap, 1'b1);
		@(posedge mclk) rsrc <= 1'b1;
		tick(3);
		rd32(REG_TOTAL_LO, "reset", P);
		chk("latch clr", wrap, 1'b0);
		chk("rerun", running, 1'b1);
		@(posedge mclk) rsrc <= 1'b0;
		wr32(REG_CTRL, 32'h25);
		whigh = 0;
		pulses(8'h5);
		tick(40);
		chk("wrap len", 32'(whigh), 32'(WC));
		rd32(REG_TOTAL_LO, "reload", P);
		wr32(REG_CTRL, 32'h22);
		wr32(REG_END_LO, 32'h0);
		wr32(REG_CMD, 32'h4);
		pulses(8'h1);
		rd32(REG_TOTAL_LO, "down", P - W);
		pulses(8'h2);
		rd32(REG_TOTAL_LO, "down end", 32'h0);
		chk("down wrap", wrap, 1'b1);
		rd32(REG_STATUS, "status", 32'hE);
		wr32(REG_CTRL, 32'h20);
		wr32(REG_PRESET_LO, W);
		@(posedge mclk) rsrc <= 1'b1;
		@(posedge mclk) rsrc <= 1'b0;
		pulses(8'h2);
		rd32(REG_TOTAL_LO, "off", W);
		// a log edge while the clock enable is low must leave no trace
		@(posedge mclk) ce <= 1'b0;
		@(posedge mclk) lsrc <= 1'b1;
		@(posedge mclk) lsrc <= 1'b0;
		@(posedge mclk) ce <= 1'b1;
		tick(3);
		chk("frozen", 32'(stbs), 32'h0);
		@(posedge mclk) lsrc <= 1'b1;
		tick(3);
		chk("log stb", 32'(stbs), 32'h1);
		rd32(REG_LOGTOT_LO, "log total", W);
		@(posedge mclk) lsrc <= 1'b0;
		for (int c = 1; c <= LOG_CODES; c++) begin
			wr32(REG_LOGINT, 32'(c));
			tod(5'h1, 6'h1, 0);
			if (c <= LOG_MIN_CODES) begin
				tod(5'h1, 6'(LOG_DIV[c] % 60), 1);
			end else begin
				tod(5'h1, 6'h0, 0);
				tod(5'(LOG_DIV[c] % 24), 6'h1, 0);
				tod(5'(LOG_DIV[c] % 24), 6'h0, 1);
			end
		end
		recov(32'h29, 1'b0);
		recov(32'h21, 1'b0);
		recov(32'h31, 1'b1);
		rd32(8'hFC, "unmapped", 32'h0);
		rd32(REG_CMD, "cmd read", 32'h0);
		conclude();
	end
endmodule // ptc_totalizer_tb_top
